/* File: shared/ddp_pkg.sv */
// package for the dual data pointer block: register addresses, field positions,
// reset values, stretch timing and carrier structs.
// assumes an 8-bit special-function register bus driven by the core.
package ddp_pkg;
    // register addresses in the special-function space
    localparam logic [7:0] DDP_ADDR_P0_LO = 8'h82;
    localparam logic [7:0] DDP_ADDR_P0_HI = 8'h83;
    localparam logic [7:0] DDP_ADDR_P1_LO = 8'h84;
    localparam logic [7:0] DDP_ADDR_P1_HI = 8'h85;
    localparam logic [7:0] DDP_ADDR_SEL = 8'h86;
    localparam logic [7:0] DDP_ADDR_CLKCTL = 8'h8E;
    // field positions
    localparam int DDP_SEL_BIT = 0;
    localparam int DDP_STRETCH_LSB = 0;
    localparam int DDP_STRETCH_W = 3;
    // reset values
    localparam logic [15:0] DDP_PTR_RST = 16'h0000;
    localparam logic DDP_SEL_RST = 1'b0;
    localparam logic [7:0] DDP_CLKCTL_RST = 8'h01;
    // timing: machine cycle in clocks, least access length in machine cycles
    localparam int DDP_CLK_PER_MC = 4;
    localparam logic [5:0] DDP_MIN_MC = 6'h02;
    localparam logic [7:0] DDP_ZERO = 8'h00;

    // pointer operation requested by instruction execution
    typedef enum logic [2:0]
    {
        DDP_OP_NONE = 3'b000,
        DDP_OP_LOAD = 3'b001,
        DDP_OP_INC = 3'b010,
        DDP_OP_XRD = 3'b011,
        DDP_OP_XWR = 3'b100
    } ddp_op_t;

    // register bus request from the core
    typedef struct packed
    {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ddp_sfr_req_t;

    // instruction request: operation plus load value or write data
    typedef struct packed
    {
        ddp_op_t op;
        logic [15:0] value;
        logic [7:0] wdata;
    } ddp_ins_req_t;

    // off-chip data access
    typedef struct packed
    {
        logic rd_n;
        logic wr_n;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ddp_xmem_t;

    typedef enum logic [1:0]
    {
        DDP_ST_IDLE = 2'b00,
        DDP_ST_ACCESS = 2'b01,
        DDP_ST_DONE = 2'b10
    } ddp_state_t;
endpackage

/* File: design/ddp_top.sv */
// dual data pointer unit: two 16-bit pointers, select register, stretch
// control and the off-chip data access sequencer.
// assumes the core issues one instruction request at a time and waits for done.
`timescale 1ns/100ps
// Notes on behaviour
// - first pointer: low byte at 82h, high byte at 83h.
// - second pointer: low byte at 84h, high byte at 85h.
// - bit 0 of 86h selects pointer: 0 first, 1 second.
// - select bits 7..1 ignored on write and read as zero.
// - incrementing the select register flips the select bit.
// - pointer instructions act only on the selected pointer; other untouched.
// - reset clears select bit, first pointer active.
// - external data access drives the full active pointer as address.
// - external access lasts 2 to 9 machine cycles; stretch resets to 1.
module ddp_top
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // special-function register bus
    input wire ddp_pkg::ddp_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // instruction requests
    input wire ddp_pkg::ddp_ins_req_t ins_req,
    output logic ins_done,
    output logic [7:0] ins_rdata,
    output logic [15:0] active_data_pointer,
    // off-chip data memory
    output ddp_pkg::ddp_xmem_t xmem,
    input wire logic [7:0] xmem_rdata
);
    import ddp_pkg::*;

    // register bank
    logic [15:0] first_pointer_q, first_pointer_d;
    logic [15:0] second_pointer_q, second_pointer_d;
    logic pointer_select_bit_q, pointer_select_bit_d;
    logic [7:0] clkctl_q, clkctl_d;
    // register read answer
    logic [7:0] sfr_rdata_q, sfr_rdata_d;
    logic sfr_hit_q, sfr_hit_d;
    // active pointer output stage
    logic [15:0] active_q, active_d;
    // access sequencer
    ddp_state_t state_q, state_d;
    logic [5:0] cnt_q, cnt_d;
    // read data synchroniser
    logic [7:0] rd0_q, rd0_d;
    logic [7:0] rd1_q, rd1_d;
    // access sequencer results
    logic done_q, done_d;
    logic [7:0] ins_rdata_q, ins_rdata_d;
    ddp_xmem_t xmem_q, xmem_d;
    logic is_write_q, is_write_d;
    // combinational helpers
    logic [15:0] cur_ptr;
    logic [15:0] cur_inc;
    logic [5:0] access_clks;

    // pointer currently chosen by the select bit
    assign cur_ptr = pointer_select_bit_q ? second_pointer_q : first_pointer_q;
    assign cur_inc = cur_ptr + 16'h0001;
    // access length in clocks: (stretch + 2) machine cycles
    assign access_clks = 6'((6'(clkctl_q[DDP_STRETCH_LSB +: DDP_STRETCH_W]) + DDP_MIN_MC)
                            * DDP_CLK_PER_MC);

    // register bank next state: bus writes then instruction updates
    always_comb
    begin
        first_pointer_d = first_pointer_q;
        second_pointer_d = second_pointer_q;
        pointer_select_bit_d = pointer_select_bit_q;
        clkctl_d = clkctl_q;
        if (sfr_req.addr == DDP_ADDR_P0_LO)
        begin
            if (sfr_req.wr)
                first_pointer_d[7:0] = sfr_req.wdata;
        end
        else if (sfr_req.addr == DDP_ADDR_P0_HI)
        begin
            if (sfr_req.wr)
                first_pointer_d[15:8] = sfr_req.wdata;
        end
        else if (sfr_req.addr == DDP_ADDR_P1_LO)
        begin
            if (sfr_req.wr)
                second_pointer_d[7:0] = sfr_req.wdata;
        end
        else if (sfr_req.addr == DDP_ADDR_P1_HI)
        begin
            if (sfr_req.wr)
                second_pointer_d[15:8] = sfr_req.wdata;
        end
        else if (sfr_req.addr == DDP_ADDR_SEL)
        begin
            // an increment written back as old+1 flips bit 0
            if (sfr_req.wr)
                pointer_select_bit_d = sfr_req.wdata[DDP_SEL_BIT];
        end
        else if (sfr_req.addr == DDP_ADDR_CLKCTL)
        begin
            if (sfr_req.wr)
                clkctl_d = sfr_req.wdata;
        end
        // instruction updates touch only the selected pointer
        if (state_q == DDP_ST_IDLE && (ins_req.op == DDP_OP_LOAD || ins_req.op == DDP_OP_INC))
        begin
            if (pointer_select_bit_q)
                second_pointer_d = (ins_req.op == DDP_OP_LOAD) ? ins_req.value : cur_inc;
            else
                first_pointer_d = (ins_req.op == DDP_OP_LOAD) ? ins_req.value : cur_inc;
        end
    end

    // register read answer: addressed register, zero for unmapped addresses
    always_comb
    begin
        sfr_hit_d = 1'b0;
        sfr_rdata_d = DDP_ZERO;
        if (sfr_req.addr == DDP_ADDR_P0_LO)
        begin
            sfr_hit_d = 1'b1;
            sfr_rdata_d = first_pointer_q[7:0];
        end
        else if (sfr_req.addr == DDP_ADDR_P0_HI)
        begin
            sfr_hit_d = 1'b1;
            sfr_rdata_d = first_pointer_q[15:8];
        end
        else if (sfr_req.addr == DDP_ADDR_P1_LO)
        begin
            sfr_hit_d = 1'b1;
            sfr_rdata_d = second_pointer_q[7:0];
        end
        else if (sfr_req.addr == DDP_ADDR_P1_HI)
        begin
            sfr_hit_d = 1'b1;
            sfr_rdata_d = second_pointer_q[15:8];
        end
        else if (sfr_req.addr == DDP_ADDR_SEL)
        begin
            sfr_hit_d = 1'b1;
            // upper bits have no storage and read as zero
            sfr_rdata_d = {7'h00, pointer_select_bit_q};
        end
        else if (sfr_req.addr == DDP_ADDR_CLKCTL)
        begin
            sfr_hit_d = 1'b1;
            sfr_rdata_d = clkctl_q;
        end
    end

    // access sequencer next state
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        ins_rdata_d = ins_rdata_q;
        xmem_d = xmem_q;
        is_write_d = is_write_q;
        case (state_q)
            DDP_ST_IDLE:
            begin
                if (ins_req.op == DDP_OP_XRD || ins_req.op == DDP_OP_XWR)
                begin
                    state_d = DDP_ST_ACCESS;
                    // strobe stays low for the whole stretched length
                    cnt_d = access_clks;
                    is_write_d = (ins_req.op == DDP_OP_XWR);
                    xmem_d.addr = cur_ptr;
                    xmem_d.wdata = ins_req.wdata;
                    xmem_d.rd_n = (ins_req.op == DDP_OP_XWR);
                    xmem_d.wr_n = (ins_req.op == DDP_OP_XRD);
                end
                else if (ins_req.op != DDP_OP_NONE)
                    done_d = 1'b1;
            end
            DDP_ST_ACCESS:
            begin
                // strobe held for the stretched length
                if (cnt_q == 6'h01)
                begin
                    state_d = DDP_ST_DONE;
                    xmem_d.rd_n = 1'b1;
                    xmem_d.wr_n = 1'b1;
                    if (!is_write_q)
                        ins_rdata_d = rd1_q;
                end
                cnt_d = cnt_q - 6'h01;
            end
            DDP_ST_DONE:
            begin
                done_d = 1'b1;
                state_d = DDP_ST_IDLE;
            end
            default:
                state_d = DDP_ST_IDLE;
        endcase
    end

    // read data synchroniser next state: two stages before any use
    always_comb
    begin
        rd0_d = xmem_rdata;
        rd1_d = rd0_q;
    end

    // selected pointer mirrored to the output
    always_comb
    begin
        active_d = cur_ptr;
    end

    // register bank state
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            first_pointer_q <= DDP_PTR_RST;
            second_pointer_q <= DDP_PTR_RST;
            pointer_select_bit_q <= DDP_SEL_RST;
            clkctl_q <= DDP_CLKCTL_RST;
        end
        else
        begin
            first_pointer_q <= first_pointer_d;
            second_pointer_q <= second_pointer_d;
            pointer_select_bit_q <= pointer_select_bit_d;
            clkctl_q <= clkctl_d;
        end
    end

    // register read answer state
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sfr_rdata_q <= DDP_ZERO;
            sfr_hit_q <= 1'b0;
        end
        else
        begin
            sfr_rdata_q <= sfr_rdata_d;
            sfr_hit_q <= sfr_hit_d;
        end
    end

    // access sequencer state
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_q <= DDP_ST_IDLE;
            cnt_q <= 6'h00;
            done_q <= 1'b0;
            ins_rdata_q <= DDP_ZERO;
            xmem_q <= '{rd_n: 1'b1, wr_n: 1'b1, addr: 16'h0000, wdata: 8'h00};
            is_write_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            ins_rdata_q <= ins_rdata_d;
            xmem_q <= xmem_d;
            is_write_q <= is_write_d;
        end
    end

    // read data synchroniser state
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rd0_q <= DDP_ZERO;
            rd1_q <= DDP_ZERO;
        end
        else
        begin
            rd0_q <= rd0_d;
            rd1_q <= rd1_d;
        end
    end

    // active pointer output stage
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            active_q <= DDP_PTR_RST;
        end
        else
        begin
            active_q <= active_d;
        end
    end

    // outputs straight from flip-flops
    assign sfr_rdata = sfr_rdata_q;
    assign sfr_hit = sfr_hit_q;
    assign ins_done = done_q;
    assign ins_rdata = ins_rdata_q;
    assign active_data_pointer = active_q;
    assign xmem = xmem_q;
endmodule

/* File: sim/ddp_xmem_model.sv */
// off-chip data memory model
// assumes active-low strobes, one core clock
`timescale 1ns/100ps
module ddp_xmem_model
(
    // clock
    input wire logic clk,
    // memory bus
    input wire ddp_pkg::ddp_xmem_t xmem,
    output logic [7:0] xmem_rdata
);
    import ddp_pkg::*;
    // address hash while read, toggles once released
    always @(posedge clk)
        xmem_rdata <= xmem.rd_n ? ~xmem_rdata : xmem.addr[7:0] ^ xmem.addr[15:8] ^ 8'h5A;
endmodule

/* File: sim/ddp_top_asserts.sv */
// port assertions for the pointer unit
// assumes one instruction at a time
`timescale 1ns/100ps
module ddp_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // watched ports
    input wire ddp_pkg::ddp_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire ddp_pkg::ddp_ins_req_t ins_req,
    input wire logic ins_done,
    input wire logic [15:0] active_data_pointer,
    input wire ddp_pkg::ddp_xmem_t xmem
);
    import ddp_pkg::*;
    logic [2:0] st_q;
    logic [5:0] lo_q;
    logic busy;
    logic mapped;
    // strobe and address decode
    assign busy = !xmem.rd_n || !xmem.wr_n;
    assign mapped = sfr_req.addr inside {[8'h82:8'h86], 8'h8E};
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // stretch shadow and strobe-low length
    always_ff @(posedge clk)
    begin
        if (!rst_b || (sfr_req.wr && sfr_req.addr == DDP_ADDR_CLKCTL))
            st_q <= rst_b ? sfr_req.wdata[2:0] : 3'h1;
        lo_q <= (rst_b && busy) ? lo_q + 6'h01 : 6'h00;
    end
    a_hit_mapped: assert property (mapped |=> sfr_hit) else $error("mapped address missed");
    a_unmapped_zero: assert property (!mapped |=> !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped answered");
    a_sel_upper_zero: assert property (sfr_req.addr == DDP_ADDR_SEL |=> sfr_rdata[7:1] == 7'h00)
        else $error("select upper bits set");
    a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> xmem.rd_n && xmem.wr_n ##1
        active_data_pointer == 16'h0000) else $error("reset state wrong");
    a_ptr_op_done: assert property (ins_req.op inside {DDP_OP_LOAD, DDP_OP_INC} |=> ins_done)
        else $error("pointer op not done");
    a_read_addr: assert property (ins_req.op == DDP_OP_XRD |=> !xmem.rd_n
        && xmem.addr == active_data_pointer) else $error("read address wrong");
    a_write_data: assert property (ins_req.op == DDP_OP_XWR |=> !xmem.wr_n
        && xmem.wdata == $past(ins_req.wdata)) else $error("write data wrong");
    a_strobe_len: assert property ($past(rst_b) && ($rose(xmem.rd_n) || $rose(xmem.wr_n)) |->
        lo_q == ({3'h0, st_q} + 6'h02) * 6'h04) else $error("strobe length wrong");
    a_done_after: assert property ($past(rst_b) && ($rose(xmem.rd_n) || $rose(xmem.wr_n))
        |-> ##[0:1] ins_done) else $error("access done missing");
endmodule
bind ddp_top ddp_chk u_chk
(
    .clk(clk),
    .rst_b(rst_b),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .ins_req(ins_req),
    .ins_done(ins_done),
    .active_data_pointer(active_data_pointer),
    .xmem(xmem)
);

/* File: sim/ddp_top_bench.sv */
// self-checking bench for the pointer unit
// assumes memory model and bound checker
`timescale 1ns/100ps
module ddp_top_bench;
    import ddp_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ddp_sfr_req_t sfr_req = '0;
    ddp_ins_req_t ins_req = '0;
    ddp_xmem_t xmem;
    logic [7:0] sfr_rdata, ins_rdata, xmem_rdata, rd, ckc, d;
    logic sfr_hit, ins_done, sel, hit;
    logic [15:0] adp, v;
    logic [15:0] ptr [2];
    int failures = 0, checks_done = 0, cyc = 0, n;
    ddp_top DUT (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .ins_req(ins_req), .ins_done(ins_done), .ins_rdata(ins_rdata), .active_data_pointer(adp),
        .xmem(xmem), .xmem_rdata(xmem_rdata));
    ddp_xmem_model mem (.clk(clk), .xmem(xmem), .xmem_rdata(xmem_rdata));
    // clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // register value as the bank should hold it
    function automatic logic [7:0] reg_exp(logic [7:0] a);
        if (a inside {[8'h82:8'h85]})
            return a[0] ? ptr[a[2]][15:8] : ptr[a[2]][7:0];
        if (a == 8'h86)
            return {7'h00, sel};
        return (a == 8'h8E) ? ckc : 8'h00;
    endfunction
    // only the mapped addresses answer on the register bus
    function automatic logic reg_map(logic [7:0] a);
        return (a inside {[8'h82:8'h86]}) || (a == 8'h8E);
    endfunction
    // cycles from the taken edge to done: stretched strobe plus one, else none
    function automatic logic [15:0] acc_cycles(ddp_op_t o);
        if (o == DDP_OP_XRD || o == DDP_OP_XWR)
            return ({13'h0000, ckc[2:0]} + 16'h0002) * 16'h0004 + 16'h0001;
        return 16'h0000;
    endfunction
    task automatic bus(logic w, logic [7:0] a, logic [7:0] dd);
        @(posedge clk);
        sfr_req <= '{w, a, dd};
        @(posedge clk);
        sfr_req.wr <= 1'b0;
        #1 rd = sfr_rdata;
        hit = sfr_hit;
    endtask
    task automatic ins(ddp_op_t o, logic [15:0] vv, logic [7:0] w);
        @(posedge clk);
        ins_req <= '{o, vv, w};
        @(posedge clk);
        ins_req.op <= DDP_OP_NONE;
        #1 n = 0;
        while (ins_done !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk("ins_done", 16'h0001, {15'h0000, ins_done});
        chk("done_cycles", acc_cycles(o), 16'(n));
        if (o == DDP_OP_LOAD)
            ptr[sel] = vv;
        if (o == DDP_OP_INC)
            ptr[sel] = ptr[sel] + 16'h0001;
        if (o == DDP_OP_XRD)
            chk("ins_rdata", {8'h00, ptr[sel][7:0] ^ ptr[sel][15:8] ^ 8'h5A}, {8'h00, ins_rdata});
        if (o[2] || o == DDP_OP_XRD)
            chk("xmem_addr", ptr[sel], xmem.addr);
        repeat (2) @(posedge clk);
        #1 chk("active_pointer", ptr[sel], adp);
    endtask
    // reset, corners, then random traffic
    initial
    begin
        void'($urandom(27));
        ptr = '{16'h0000, 16'h0000};
        sel = 1'b0;
        ckc = 8'h01;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 8'h80; a < 8'h90; a++)
        begin
            bus(1'b0, a[7:0], 8'h00);
            chk("reg_read", {8'h00, reg_exp(a[7:0])}, {8'h00, rd});
            chk("reg_hit", {15'h0000, reg_map(a[7:0])}, {15'h0000, hit});
        end
        ins(DDP_OP_LOAD, 16'hFFFF, 8'h00);
        ins(DDP_OP_INC, 16'h0000, 8'h00);
        bus(1'b1, 8'h86, 8'hFF);
        sel = 1'b1;
        ins(DDP_OP_LOAD, 16'h00FF, 8'h00);
        ins(DDP_OP_INC, 16'h0000, 8'h00);
        for (int i = 0; i < 120; i++)
        begin
            v = 16'($urandom);
            d = 8'($urandom);
            case ($urandom_range(5, 0))
                0: ins(DDP_OP_LOAD, v, d);
                1: ins(DDP_OP_INC, v, d);
                2: ins(DDP_OP_XWR, v, d);
                3:
                begin
                    bus(1'b1, 8'h8E, d);
                    ckc = d;
                    ins(DDP_OP_XRD, v, d);
                end
                4:
                begin
                    bus(1'b1, DDP_ADDR_SEL, {7'h00, sel} + 8'h01);
                    sel = ~sel;
                end
                default:
                begin
                    bus(1'b1, 8'h82 + {6'h00, v[1:0]}, d);
                    if (v[0])
                        ptr[v[1]][15:8] = d;
                    else
                        ptr[v[1]][7:0] = d;
                end
            endcase
            bus(1'b0, 8'h80 + {4'h0, v[15:12]}, 8'h00);
            chk("reg_read", {8'h00, reg_exp(8'h80 + {4'h0, v[15:12]})}, {8'h00, rd});
            chk("reg_hit", {15'h0000, reg_map(8'h80 + {4'h0, v[15:12]})}, {15'h0000, hit});
            repeat (2) @(posedge clk);
            #1 chk("active_pointer", ptr[sel], adp);
        end
        tally_and_finish();
    end
endmodule
